// >>> scc_map.svh
// offsets, field positions, reset values and timing counts of the strap block
//
// Contract
// - at reset release sample both memory data buses; bus a is low half
// - lines idle high by weak pull-up; board pulls down to invert a strap
// - only bits 15:12, 10 and 0 are software writable; rest stay sampled
// - bus architecture decoded from bits 2 and 17, frozen after start-up
// - bit 3 sets both video clock pins as inputs or outputs
// - bits 7:4 are general-purpose status only, read back unchanged
// - bit 11 from bus a line 8, bit 8 from bus a line 11
// - bit 9 picks the host port mechanism that wakes the display
// - memory mode decoded from bits 13, 14 and 16 together
// - bit 15 tells the host interface the host processor width
// - bits 18 and 19 preset panel type select bits 0 and 1
// - bit 20 set makes the local bus run from a double-rate clock
// - bits 27:22 preset local bus interface register one bits 5:0
// - bits 31:28 preset local bus interface register zero bits 7:4
// - bit 11 low forces detectors to voltage register bits 4:0
// - bit 15 low means 16-bit host port, high means 32-bit
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SCC_OFF_STRAP 8'h00
`define SCC_OFF_STATUS 8'h04
`define SCC_OFF_VOLT 8'h08
`define SCC_OFF_PANEL 8'h0c
`define SCC_OFF_LBI0 8'h10
`define SCC_OFF_LBI1 8'h14

// ----------------------------------------------------------------------
// strap field positions
// ----------------------------------------------------------------------
`define SCC_BIT_ROM 0
`define SCC_BIT_ARCH_LO 2
`define SCC_BIT_VCLK_DIR 3
`define SCC_BIT_GP_LO 4
`define SCC_BIT_GP_HI 7
`define SCC_BIT_GP8 8
`define SCC_BIT_WAKE 9
`define SCC_BIT_VOLT 11
`define SCC_BIT_MEM_LO 13
`define SCC_BIT_MEM_MID 14
`define SCC_BIT_HOST 15
`define SCC_BIT_MEM_HI 16
`define SCC_BIT_ARCH_HI 17
`define SCC_BIT_PANEL0 18
`define SCC_BIT_PANEL1 19
`define SCC_BIT_LB_2X 20
`define SCC_BIT_LBI1_LO 22
`define SCC_BIT_LBI1_HI 27
`define SCC_BIT_LBI0_LO 28
`define SCC_BIT_LBI0_HI 31
`define SCC_BUS_A_VOLT_LINE 8
`define SCC_BUS_A_GP8_LINE 11

// ----------------------------------------------------------------------
// reset values, masks and timing
// ----------------------------------------------------------------------
`define SCC_STRAP_RESET 32'hffffffff
`define SCC_STRAP_WR_MASK 32'h0000f401
`define SCC_VOLT_RESET 6'h00
`define SCC_PANEL_RESET 8'h00
`define SCC_LBI_RESET 8'h00
`define SCC_SETTLE_CYCLES 2'h3

`endif

// >>> scc_pkg.sv
// types shared by the strap configuration block
package scc_pkg;

   typedef enum logic [1:0] {
      SCC_SETTLE = 2'b00,
      SCC_RUN = 2'b01
   } scc_state_t;

   // decoded configuration handed to the rest of the chip
   typedef struct packed {
      logic bios_rom_mapped_out;
      logic [1:0] bus_arch;
      logic video_clk_is_output;
      logic wake_port_sel;
      logic volt_force;
      logic volt_auto_en;
      logic [4:0] volt_level;
      logic [2:0] mem_mode;
      logic host_32bit;
      logic local_bus_2x_clk;
      logic [7:0] panel_type;
      logic [7:0] lbi_reg0;
      logic [7:0] lbi_reg1;
   } scc_cfg_t;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } scc_req_t;

endpackage

// >>> scc_pullup_model.sv
// memory data lines: weak pull-ups, board pull-downs, later traffic
`timescale 1ns/1ps
`default_nettype none

module scc_pullup_model (
   input wire logic clk,
   input wire logic traffic,
   input wire logic [31:0] pull_down,
   output logic [15:0] bus_a,
   output logic [15:0] bus_b
);
   logic [15:0] cnt = 16'h0;

   always @(posedge clk) begin
      cnt <= cnt + 16'h1;
   end
   // traffic changes every cycle so a late sample cannot pass
   assign bus_a = traffic ? cnt : ~pull_down[15:0];
   assign bus_b = traffic ? ~cnt : ~pull_down[31:16];
endmodule

`default_nettype wire

// >>> scc_strap_config.sv
// strap capture, configuration registers and decoded configuration outputs
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_strap_config (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] mem_data_bus_a_in,
   input wire logic [15:0] mem_data_bus_b_in,
   input wire scc_pkg::scc_req_t req,
   output logic [31:0] rdata,
   output logic capture_done,
   output logic video_clock_pin_one_oe,
   output logic video_clock_pin_two_oe,
   output scc_pkg::scc_cfg_t cfg
);

   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   logic [31:0] pins_raw;
   logic [31:0] pins_sync;
   logic [31:0] strap_sampled;

   assign pins_raw = {mem_data_bus_b_in, mem_data_bus_a_in};

   scc_sync2 #(
      .WIDTH(32),
      .RESET_VAL(`SCC_STRAP_RESET)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .din(pins_raw),
      .dout(pins_sync)
   );

   // bus a lines 8 and 11 land swapped in the strap word
   always_comb begin
      strap_sampled = pins_sync;
      strap_sampled[`SCC_BIT_VOLT] = pins_sync[`SCC_BUS_A_VOLT_LINE];
      strap_sampled[`SCC_BIT_GP8] = pins_sync[`SCC_BUS_A_GP8_LINE];
   end

   // ----------------------------------------------------------------------
   // capture sequencer
   // ----------------------------------------------------------------------
   scc_pkg::scc_state_t state;
   scc_pkg::scc_state_t next_state;
   logic [1:0] settle_cnt;
   logic [1:0] next_settle_cnt;
   logic capture;

   // the chain needs two edges after release before it shows the pins
   always_comb begin
      next_state = state;
      next_settle_cnt = settle_cnt;
      capture = 1'b0;
      case (state)
         scc_pkg::SCC_SETTLE: begin
            if (settle_cnt == `SCC_SETTLE_CYCLES - 2'h1) begin
               capture = 1'b1;
               next_state = scc_pkg::SCC_RUN;
            end else begin
               next_settle_cnt = settle_cnt + 2'h1;
            end
         end
         scc_pkg::SCC_RUN: begin
            next_state = scc_pkg::SCC_RUN;
         end
         default: begin
            next_state = scc_pkg::SCC_SETTLE;
            next_settle_cnt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= scc_pkg::SCC_SETTLE;
         settle_cnt <= 2'h0;
      end else begin
         state <= next_state;
         settle_cnt <= next_settle_cnt;
      end
   end

   assign capture_done = (state == scc_pkg::SCC_RUN);

   // ----------------------------------------------------------------------
   // register write decode
   // ----------------------------------------------------------------------
   logic wr_strap;
   logic wr_volt;
   logic wr_panel;
   logic wr_lbi0;
   logic wr_lbi1;

   always_comb begin
      wr_strap = 1'b0;
      wr_volt = 1'b0;
      wr_panel = 1'b0;
      wr_lbi0 = 1'b0;
      wr_lbi1 = 1'b0;
      if (req.wr) begin
         if (req.addr == `SCC_OFF_STRAP) begin
            wr_strap = 1'b1;
         end else if (req.addr == `SCC_OFF_VOLT) begin
            wr_volt = 1'b1;
         end else if (req.addr == `SCC_OFF_PANEL) begin
            wr_panel = 1'b1;
         end else if (req.addr == `SCC_OFF_LBI0) begin
            wr_lbi0 = 1'b1;
         end else if (req.addr == `SCC_OFF_LBI1) begin
            wr_lbi1 = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   logic [31:0] strap_config;
   logic [31:0] next_strap_config;
   logic [5:0] voltage_control_register;
   logic [5:0] next_voltage_control_register;
   logic [7:0] panel_type_register;
   logic [7:0] next_panel_type_register;
   logic [7:0] local_bus_interface0;
   logic [7:0] next_local_bus_interface0;
   logic [7:0] local_bus_interface1;
   logic [7:0] next_local_bus_interface1;

   // capture wins over a software write landing in the same cycle
   always_comb begin
      next_strap_config = strap_config;
      next_voltage_control_register = voltage_control_register;
      next_panel_type_register = panel_type_register;
      next_local_bus_interface0 = local_bus_interface0;
      next_local_bus_interface1 = local_bus_interface1;
      if (wr_strap) begin
         next_strap_config = (strap_config & ~`SCC_STRAP_WR_MASK) |
                             (req.wdata & `SCC_STRAP_WR_MASK);
      end
      if (wr_volt) begin
         next_voltage_control_register = req.wdata[5:0];
      end
      if (wr_panel) begin
         next_panel_type_register = req.wdata[7:0];
      end
      if (wr_lbi0) begin
         next_local_bus_interface0 = req.wdata[7:0];
      end
      if (wr_lbi1) begin
         next_local_bus_interface1 = req.wdata[7:0];
      end
      if (capture) begin
         next_strap_config = strap_sampled;
         next_panel_type_register[0] =
            strap_sampled[`SCC_BIT_PANEL0];
         next_panel_type_register[1] =
            strap_sampled[`SCC_BIT_PANEL1];
         next_local_bus_interface1[5:0] =
            strap_sampled[`SCC_BIT_LBI1_HI:`SCC_BIT_LBI1_LO];
         next_local_bus_interface0[7:4] =
            strap_sampled[`SCC_BIT_LBI0_HI:`SCC_BIT_LBI0_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         strap_config <= `SCC_STRAP_RESET;
         voltage_control_register <= `SCC_VOLT_RESET;
         panel_type_register <= `SCC_PANEL_RESET;
         local_bus_interface0 <= `SCC_LBI_RESET;
         local_bus_interface1 <= `SCC_LBI_RESET;
      end else begin
         strap_config <= next_strap_config;
         voltage_control_register <= next_voltage_control_register;
         panel_type_register <= next_panel_type_register;
         local_bus_interface0 <= next_local_bus_interface0;
         local_bus_interface1 <= next_local_bus_interface1;
      end
   end

   // ----------------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------------
   logic [31:0] next_rdata;

   // unmapped offsets and idle cycles read as zero
   always_comb begin
      next_rdata = 32'h00000000;
      if (req.rd) begin
         if (req.addr == `SCC_OFF_STRAP) begin
            next_rdata = strap_config;
         end else if (req.addr == `SCC_OFF_STATUS) begin
            next_rdata = {31'h00000000, capture_done};
         end else if (req.addr == `SCC_OFF_VOLT) begin
            next_rdata = {26'h0000000, voltage_control_register};
         end else if (req.addr == `SCC_OFF_PANEL) begin
            next_rdata = {24'h000000, panel_type_register};
         end else if (req.addr == `SCC_OFF_LBI0) begin
            next_rdata = {24'h000000, local_bus_interface0};
         end else if (req.addr == `SCC_OFF_LBI1) begin
            next_rdata = {24'h000000, local_bus_interface1};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // decoded configuration
   // ----------------------------------------------------------------------
   scc_pkg::scc_cfg_t next_cfg;
   logic next_vclk_oe;
   logic vclk_oe;

   // registered so every consumer sees one consistent snapshot
   always_comb begin
      next_cfg.bios_rom_mapped_out = strap_config[`SCC_BIT_ROM];
      next_cfg.bus_arch = {strap_config[`SCC_BIT_ARCH_HI],
                           strap_config[`SCC_BIT_ARCH_LO]};
      next_cfg.video_clk_is_output =
         strap_config[`SCC_BIT_VCLK_DIR];
      next_cfg.wake_port_sel = strap_config[`SCC_BIT_WAKE];
      next_cfg.volt_force = ~strap_config[`SCC_BIT_VOLT];
      // forcing ignores the auto-detect bit entirely
      next_cfg.volt_auto_en = strap_config[`SCC_BIT_VOLT] &
                              voltage_control_register[5];
      next_cfg.volt_level = voltage_control_register[4:0];
      next_cfg.mem_mode = {strap_config[`SCC_BIT_MEM_HI],
                           strap_config[`SCC_BIT_MEM_MID],
                           strap_config[`SCC_BIT_MEM_LO]};
      next_cfg.host_32bit = strap_config[`SCC_BIT_HOST];
      next_cfg.local_bus_2x_clk = strap_config[`SCC_BIT_LB_2X];
      next_cfg.panel_type = panel_type_register;
      next_cfg.lbi_reg0 = local_bus_interface0;
      next_cfg.lbi_reg1 = local_bus_interface1;
      next_vclk_oe = strap_config[`SCC_BIT_VCLK_DIR];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg <= '0;
         vclk_oe <= 1'b0;
      end else begin
         cfg <= next_cfg;
         vclk_oe <= next_vclk_oe;
      end
   end

   // both video clock pins share one direction
   assign video_clock_pin_one_oe = vclk_oe;
   assign video_clock_pin_two_oe = vclk_oe;

endmodule

`default_nettype wire

// >>> scc_strap_config_tb_top.sv
// self-checking testbench of the strap configuration block
`timescale 1ns/1ps
`default_nettype none

module scc_strap_config_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic traffic = 1'b0;
   logic [31:0] pd = 32'h0;
   logic [15:0] bus_a;
   logic [15:0] bus_b;
   scc_pkg::scc_req_t req = '0;
   logic [31:0] rdata;
   logic capture_done;
   logic oe1;
   logic oe2;
   scc_pkg::scc_cfg_t cfg;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [31:0] w;

   always #25 clk = ~clk;

   scc_pullup_model scc_pullup_model_inst (.clk(clk), .traffic(traffic),
      .pull_down(pd), .bus_a(bus_a), .bus_b(bus_b));
   scc_strap_config scc_strap_config_inst (.clk(clk), .rst(rst),
      .mem_data_bus_a_in(bus_a), .mem_data_bus_b_in(bus_b), .req(req),
      .rdata(rdata), .capture_done(capture_done),
      .video_clock_pin_one_oe(oe1), .video_clock_pin_two_oe(oe2),
      .cfg(cfg));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic summarize;
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(nm, e, rdata);
   endtask

   // write then read back to back, with no idle cycle between the strobes
   task automatic wr_rd(input string nm, input logic [31:0] d,
                        input logic [31:0] e);
      @(posedge clk);
      req.addr <= 8'h00;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(nm, e, rdata);
   endtask

   task automatic chk_dec(input logic [31:0] v);
      chk("cfg", {21'h0, v[0], v[17], v[2], v[3], v[9], ~v[11], v[16],
         v[14], v[13], v[15], v[20]}, {21'h0, cfg.bios_rom_mapped_out,
         cfg.bus_arch, cfg.video_clk_is_output, cfg.wake_port_sel,
         cfg.volt_force, cfg.mem_mode, cfg.host_32bit,
         cfg.local_bus_2x_clk});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_capture(input logic [31:0] m);
      @(posedge clk);
      pd <= m;
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      w = {~m[31:12], ~m[8], ~m[10:9], ~m[11], ~m[7:0]};
      for (int i = 0; i < 8 && capture_done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      repeat (2) @(posedge clk);
      #1;
      chk_dec(w);
      chk("oe", {30'h0, w[3], w[3]}, {30'h0, oe1, oe2});
      rdc("strap", 8'h00, w);
      rdc("panel", 8'h0c, {30'h0, w[19:18]});
      rdc("lbi0", 8'h10, {24'h0, w[31:28], 4'h0});
      rdc("lbi1", 8'h14, {26'h0, w[27:22]});
      rdc("volt", 8'h08, 32'h0);
   endtask

   task automatic t_hold;
      traffic <= 1'b1;
      repeat (20) @(posedge clk);
      rdc("held", 8'h00, w);
      chk_dec(w);
      traffic <= 1'b0;
   endtask

   task automatic t_regs;
      rdc("status", 8'h04, 32'h1);
      wr(8'h04, 32'h0);
      rdc("status_ro", 8'h04, 32'h1);
      rdc("unmapped", 8'h18, 32'h0);
      wr(8'h08, 32'h25);
      rdc("volt_rw", 8'h08, 32'h25);
      chk("volt", {26'h0, w[11], 5'h05},
         {26'h0, cfg.volt_auto_en, cfg.volt_level});
      wr(8'h0c, 32'h000000a6);
      wr(8'h10, 32'h0000005b);
      wr(8'h14, 32'h000000c9);
      rdc("panel_rw", 8'h0c, 32'h000000a6);
      rdc("lbi0_rw", 8'h10, 32'h0000005b);
      rdc("lbi1_rw", 8'h14, 32'h000000c9);
      chk("cfg_regs", 32'h00a65bc9, {8'h0, cfg.panel_type, cfg.lbi_reg0,
         cfg.lbi_reg1});
   endtask

   task automatic t_sw_write;
      wr_rd("sw_clr", 32'h0, w & ~32'h0000f401);
      chk_dec(w & ~32'h0000f401);
      wr_rd("sw_set", 32'hffffffff, w | 32'h0000f401);
      chk_dec(w | 32'h0000f401);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         summarize;
      end
   end

   // complementary pull-down patterns give every strap both levels
   initial begin
      for (int k = 0; k < 2; k++) begin
         t_capture(k == 0 ? 32'h3c5aa5c3 : ~32'h3c5aa5c3);
         t_hold;
         t_regs;
         t_sw_write;
      end
      summarize;
   end
endmodule

`default_nettype wire

// >>> scc_strap_props.sv
// concurrent checks on the strap configuration block ports
`timescale 1ns/1ps
`default_nettype none

module scc_strap_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] mem_data_bus_a_in,
   input wire logic [15:0] mem_data_bus_b_in,
   input wire scc_pkg::scc_req_t req,
   input wire logic [31:0] rdata,
   input wire logic capture_done,
   input wire logic video_clock_pin_one_oe,
   input wire logic video_clock_pin_two_oe,
   input wire scc_pkg::scc_cfg_t cfg
);
   // ----------------------------------------------------------------
   // sequences and properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // pins must stay static across the first four edges after release
   sequence s_release;
      $fell(rst) ##4 1;
   endsequence

   sequence s_wr_rd;
      req.wr && req.addr == 8'h00 && capture_done
         ##1 req.rd && req.addr == 8'h00;
   endsequence

   a_capture_time: assert property (
      $fell(rst) |-> !capture_done [*3] ##1 capture_done)
      else $error("capture not done three edges after release");
   a_done_holds: assert property (capture_done |=> capture_done)
      else $error("capture done dropped");
   a_cap_fields: assert property (s_release |->
      cfg.bus_arch == {$past(mem_data_bus_b_in[1], 4),
                       $past(mem_data_bus_a_in[2], 4)}
      && cfg.panel_type[1:0] == $past(mem_data_bus_b_in[3:2], 4)
      && cfg.volt_force == !$past(mem_data_bus_a_in[8], 4)
      && video_clock_pin_one_oe == $past(mem_data_bus_a_in[3], 4))
      else $error("captured fields wrong");
   a_lbi_preset: assert property (s_release |->
      cfg.lbi_reg0[7:4] == $past(mem_data_bus_b_in[15:12], 4)
      && cfg.lbi_reg1[5:0] == $past(mem_data_bus_b_in[11:6], 4))
      else $error("local bus presets wrong");
   a_fixed_fields: assert property ($past(capture_done, 2) |->
      $stable({cfg.bus_arch, cfg.video_clk_is_output, cfg.wake_port_sel,
               cfg.volt_force, cfg.local_bus_2x_clk, cfg.mem_mode[2]}))
      else $error("read-only field changed");
   a_oe_match: assert property (
      video_clock_pin_one_oe == cfg.video_clk_is_output
      && video_clock_pin_two_oe == cfg.video_clk_is_output)
      else $error("video clock direction mismatch");
   a_volt_force: assert property (cfg.volt_force |-> !cfg.volt_auto_en)
      else $error("auto detect while forced");
   a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");
   a_status_read: assert property (req.rd && req.addr == 8'h04
      |=> rdata == {31'h0, $past(capture_done)})
      else $error("status read wrong");
   a_unmapped_zero: assert property (req.rd && req.addr == 8'h18
      |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_sw_write: assert property (s_wr_rd |=>
      rdata[15:12] == $past(req.wdata[15:12], 2)
      && rdata[10] == $past(req.wdata[10], 2)
      && rdata[0] == $past(req.wdata[0], 2))
      else $error("writable strap bits not written");
endmodule

bind scc_strap_config scc_strap_props scc_strap_props_inst (.clk, .rst,
   .mem_data_bus_a_in, .mem_data_bus_b_in, .req, .rdata, .capture_done,
   .video_clock_pin_one_oe, .video_clock_pin_two_oe, .cfg);

`default_nettype wire

// >>> scc_sync2.sv
// two-stage synchroniser for static pin levels
`timescale 1ns/1ps
`default_nettype none

module scc_sync2 #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_dout;

   always_comb begin
      next_meta = din;
      next_dout = meta;
   end

   // reset to the pulled-up level so an idle line reads as no strap
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end

endmodule

`default_nettype wire
